// ===== core/rcwl_pkg.sv
package rcwl_pkg;

  // ----------------------------------------
  // sources and fields
  // ----------------------------------------
  localparam logic [2:0] SRC_LBUS = 3'h0;
  localparam logic [2:0] SRC_RSVD = 3'h1;
  localparam logic [2:0] SRC_I2C = 3'h2;
  localparam logic [2:0] SRC_HC_BASE = 3'h3;
  localparam logic [6:0] EE_CALL_ADDR = 7'h50;
  localparam logic [7:0] FLASH_STEP = 8'h08;
  localparam int NBYTES = 8;
  localparam int BOOT_SEQUENCE_SELECT_HI = 31;
  localparam int BOOT_SEQUENCE_SELECT_LO = 30;
  localparam logic [1:0] BOOT_SEQUENCE_SELECT_OFF = 2'h0;
  localparam int PLL_LOCK_BIT = 31;
  localparam int PLL_MODE_HI = 30;
  localparam int PLL_MODE_LO = 24;
  localparam logic [31:0] BLANK_WORD = 32'hFFFFFFFF;
  // status bits
  localparam int RS_BSF = 0;
  localparam int RS_I2C = 1;
  localparam int RS_OVR = 2;
  localparam int RS_HC = 3;
  // arbitrary plain hardcoded defaults
  localparam logic [31:0] HC_LOW [5] = '{32'h00000001, 32'h00000002, 32'h00000003, 32'h00000004, 32'h00000005};
  localparam logic [31:0] HC_HIGH [5] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};

  typedef struct packed {
    logic [31:0] low;
    logic [31:0] high;
  } rcwl_word_t;

  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } rcwl_rd_req_t;

endpackage : rcwl_pkg

// ===== core/rcwl_sync.sv
`timescale 1ns/1ps
module rcwl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic stable
);
  logic [W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  assign stable = (s2_q == s3_q);
  assign q = s3_q;
endmodule : rcwl_sync

// ===== core/rcwl_top.sv
`timescale 1ns/1ps
module rcwl_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // board reset lines
  input wire logic power_on_reset_line_n,
  input wire logic hard_reset_line_in,
  output logic hard_reset_line_oe,
  output logic hard_reset_line_out,
  input wire logic soft_reset_line_in,
  output logic soft_reset_line_oe,
  output logic soft_reset_line_out,
  input wire logic [2:0] reset_source_strap,
  // local bus byte reads
  output rcwl_pkg::rcwl_rd_req_t flash_rd,
  input wire logic flash_ack,
  input wire logic [7:0] flash_data,
  // i2c word loader (byte engine outside)
  output logic i2c_rd_req,
  output logic [6:0] i2c_call_addr,
  input wire logic i2c_ack,
  input wire logic i2c_err,
  input wire logic [7:0] i2c_data,
  output logic i2c_in_reset,
  // boot sequencer engine
  output logic boot_seq_start,
  input wire logic boot_seq_done,
  input wire logic boot_seq_crc_bad,
  // debug override
  input wire logic dbg_override_en,
  input wire logic [31:0] dbg_override_low,
  input wire logic [31:0] dbg_override_high,
  input wire logic pll_locked,
  // read-only views
  output logic [31:0] config_word_low,
  output logic [31:0] config_word_high,
  output logic [31:0] reset_status_reg,
  output logic [31:0] system_pll_mode_reg,
  output logic core_in_reset
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pins_sync;
  logic pins_stable;
  rcwl_sync #(.W(6)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({power_on_reset_line_n, hard_reset_line_in, soft_reset_line_in, reset_source_strap}),
    .q(pins_sync),
    .stable(pins_stable)
  );
  logic por_n_s, hard_reset_line_s;
  assign por_n_s = pins_sync[5];
  assign hard_reset_line_s = pins_sync[4];

  // ----------------------------------------
  // strap capture and override latch
  // ----------------------------------------
  logic [2:0] src_q;
  logic ovr_armed_q;
  rcwl_pkg::rcwl_word_t ovr_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_q <= rcwl_pkg::SRC_LBUS;
    end else if (!por_n_s && pins_stable) begin
      src_q <= pins_sync[2:0];
    end
  end

  // clearing the enable does not disarm; only power-on or arst_n does
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_armed_q <= 1'b0;
      ovr_q <= '0;
    end else if (!por_n_s) begin
      ovr_armed_q <= 1'b0;
    end else if (dbg_override_en) begin
      ovr_armed_q <= 1'b1;
      ovr_q <= '{low: dbg_override_low, high: dbg_override_high};
    end
  end

  // ----------------------------------------
  // load sequence
  // ----------------------------------------
  typedef enum logic [2:0] {S_POR, S_PICK, S_FLASH, S_I2C, S_HOLD, S_BOOT, S_RUN} rcwl_state_t;
  rcwl_state_t st_q;
  logic [2:0] idx_q;
  logic [63:0] shift_q;
  rcwl_pkg::rcwl_word_t word_q;
  logic bsf_q, from_i2c_q, used_ovr_q, used_hc_q;
  logic rd_req_q, i2c_req_q, boot_start_q;
  logic [23:0] rd_addr_q;
  logic [2:0] hc_idx;
  assign hc_idx = 3'(src_q - rcwl_pkg::SRC_HC_BASE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_POR;
      idx_q <= '0;
      shift_q <= '0;
      word_q <= '0;
      bsf_q <= 1'b0;
      from_i2c_q <= 1'b0;
      used_ovr_q <= 1'b0;
      used_hc_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
      i2c_req_q <= 1'b0;
      boot_start_q <= 1'b0;
    end else if (!por_n_s) begin
      st_q <= S_POR;
      bsf_q <= 1'b0;
      rd_req_q <= 1'b0;
      i2c_req_q <= 1'b0;
      boot_start_q <= 1'b0;
    end else begin
      boot_start_q <= 1'b0;
      case (st_q)
        S_POR: begin
          st_q <= S_PICK;
        end
        S_PICK: begin
          idx_q <= '0;
          from_i2c_q <= 1'b0;
          used_hc_q <= 1'b0;
          used_ovr_q <= 1'b0;
          if (src_q == rcwl_pkg::SRC_I2C) begin
            from_i2c_q <= 1'b1;
            i2c_req_q <= 1'b1;
            st_q <= S_I2C;
          end else if (src_q >= rcwl_pkg::SRC_HC_BASE) begin
            word_q <= '{low: rcwl_pkg::HC_LOW[hc_idx], high: rcwl_pkg::HC_HIGH[hc_idx]};
            used_hc_q <= 1'b1;
            st_q <= S_HOLD;
          end else begin
            // reserved 001 treated as local bus, undefined anyway
            rd_req_q <= 1'b1;
            rd_addr_q <= '0;
            st_q <= S_FLASH;
          end
        end
        S_FLASH: begin
          if (flash_ack) begin
            shift_q <= {shift_q[55:0], flash_data};
            rd_addr_q <= rd_addr_q + 24'(rcwl_pkg::FLASH_STEP);
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(rcwl_pkg::NBYTES - 1)) begin
              rd_req_q <= 1'b0;
              st_q <= S_HOLD;
              // blank flash bytes pass through untouched: invalid word, pll won't lock
              if (ovr_armed_q) begin
                word_q <= ovr_q;
                used_ovr_q <= 1'b1;
              end else begin
                word_q <= '{low: shift_q[55:24], high: {shift_q[23:0], flash_data}};
              end
            end
          end
        end
        S_I2C: begin
          if (i2c_err) begin
            i2c_req_q <= 1'b0;
            bsf_q <= 1'b1;
            st_q <= S_HOLD;
          end else if (i2c_ack) begin
            shift_q <= {shift_q[55:0], i2c_data};
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(rcwl_pkg::NBYTES - 1)) begin
              i2c_req_q <= 1'b0;
              // override deliberately ignored on this path
              word_q <= '{low: shift_q[55:24], high: {shift_q[23:0], i2c_data}};
              st_q <= S_HOLD;
            end
          end
        end
        S_HOLD: begin
          if (hard_reset_line_s && pins_stable) begin
            if (word_q.high[rcwl_pkg::BOOT_SEQUENCE_SELECT_HI:rcwl_pkg::BOOT_SEQUENCE_SELECT_LO] != rcwl_pkg::BOOT_SEQUENCE_SELECT_OFF) begin
              boot_start_q <= 1'b1;
              st_q <= S_BOOT;
            end else begin
              st_q <= S_RUN;
            end
          end
        end
        S_BOOT: begin
          // crc or preamble trouble is not recorded anywhere
          if (boot_seq_done) begin
            st_q <= S_RUN;
          end
        end
        S_RUN: begin
          st_q <= S_RUN;
        end
        default: begin
          st_q <= S_POR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pins and read-only views
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hard_reset_line_oe <= 1'b1;
      soft_reset_line_oe <= 1'b1;
      core_in_reset <= 1'b1;
      i2c_in_reset <= 1'b1;
    end else begin
      hard_reset_line_oe <= (st_q == S_POR) || (st_q == S_PICK) || (st_q == S_FLASH) || (st_q == S_I2C);
      soft_reset_line_oe <= (st_q != S_RUN) && (st_q != S_BOOT);
      core_in_reset <= (st_q != S_RUN);
      i2c_in_reset <= (st_q == S_HOLD) || (st_q == S_POR) || (st_q == S_PICK) || (st_q == S_FLASH);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hard_reset_line_out <= 1'b0;
      soft_reset_line_out <= 1'b0;
      flash_rd <= '0;
      i2c_rd_req <= 1'b0;
      i2c_call_addr <= rcwl_pkg::EE_CALL_ADDR;
      boot_seq_start <= 1'b0;
      config_word_low <= '0;
      config_word_high <= '0;
      reset_status_reg <= '0;
      system_pll_mode_reg <= '0;
    end else begin
      hard_reset_line_out <= 1'b0;
      soft_reset_line_out <= 1'b0;
      flash_rd <= '{req: rd_req_q, addr: rd_addr_q};
      i2c_rd_req <= i2c_req_q;
      i2c_call_addr <= rcwl_pkg::EE_CALL_ADDR;
      boot_seq_start <= boot_start_q;
      config_word_low <= word_q.low;
      config_word_high <= word_q.high;
      reset_status_reg <= '0;
      reset_status_reg[rcwl_pkg::RS_BSF] <= bsf_q;
      reset_status_reg[rcwl_pkg::RS_I2C] <= from_i2c_q;
      reset_status_reg[rcwl_pkg::RS_OVR] <= used_ovr_q;
      reset_status_reg[rcwl_pkg::RS_HC] <= used_hc_q;
      system_pll_mode_reg <= '0;
      system_pll_mode_reg[rcwl_pkg::PLL_LOCK_BIT] <= pll_locked;
      system_pll_mode_reg[rcwl_pkg::PLL_MODE_HI:rcwl_pkg::PLL_MODE_LO] <=
        word_q.low[rcwl_pkg::PLL_MODE_HI:rcwl_pkg::PLL_MODE_LO];
    end
  end

endmodule : rcwl_top

// ===== test/rcwl_byte_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// byte source: local-bus flash or i2c eeprom
// ----------------------------------------
module rcwl_byte_src (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request side
  input wire logic req,
  input wire logic [63:0] image,
  input wire logic [3:0] wait_cycles,
  input wire logic fail,
  // answer side
  output logic ack,
  output logic err,
  output logic [7:0] data
);
  logic [3:0] cnt_q;
  logic [2:0] idx_q;
  // idle data toggles between the last byte and its inverse each cycle, so a late sample is caught
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {cnt_q, idx_q, ack, err, data} <= '0;
    end else if (req && !ack && !err && cnt_q > wait_cycles) begin
      ack <= !fail;
      err <= fail;
      data <= image[63 - 8 * idx_q -: 8];
      idx_q <= idx_q + 3'h1;
      cnt_q <= 4'h0;
    end else begin
      {ack, err} <= 2'h0;
      data <= ~data;
      cnt_q <= req ? cnt_q + 4'h1 : 4'h0;
      if (!req) idx_q <= 3'h0;
    end
  end
endmodule : rcwl_byte_src

// ===== test/rcwl_top_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module rcwl_top_bench;
  localparam logic [63:0] IMG_A = 64'h1A2B3C4D00600000;
  localparam logic [63:0] IMG_B = 64'h7654321009ABCDEF;
  localparam logic [63:0] IMG_BOOT = 64'h1A2B3C4D40600000;
  localparam logic [63:0] OVR = 64'h55AA0F0F00C00001;
  logic clk = 0, arst_n = 0, por_n = 0, ext_hard = 0, en = 0, done = 0, crc = 0, seen_boot = 0, fail = 0;
  // power-on disarms the override, so arming happens inside the load that must use it
  logic arm_ovr = 0;
  logic i_rst;
  logic [2:0] strap = 3'h0;
  logic [3:0] wt = 4'h9;
  logic [63:0] image = '0;
  int errors = 0, comparisons = 0, cycles = 0;
  logic hard_oe, soft_oe, f_ack, i_req, i_ack, i_err, start, cir;
  logic [7:0] f_data, i_data;
  logic [31:0] lo, hi, st, pll;
  rcwl_pkg::rcwl_rd_req_t f_rd;
  always #4 clk = ~clk;
  // lines are pulled up; only open-drain pulls reach them
  rcwl_top dut (.clk(clk), .arst_n(arst_n), .power_on_reset_line_n(por_n),
    .hard_reset_line_in(!hard_oe && ext_hard), .hard_reset_line_oe(hard_oe), .hard_reset_line_out(),
    .soft_reset_line_in(!soft_oe), .soft_reset_line_oe(soft_oe), .soft_reset_line_out(),
    .reset_source_strap(strap), .flash_rd(f_rd), .flash_ack(f_ack), .flash_data(f_data),
    .i2c_rd_req(i_req), .i2c_call_addr(), .i2c_ack(i_ack), .i2c_err(i_err), .i2c_data(i_data),
    .i2c_in_reset(i_rst), .boot_seq_start(start), .boot_seq_done(done), .boot_seq_crc_bad(crc),
    .dbg_override_en(en), .dbg_override_low(OVR[63:32]), .dbg_override_high(OVR[31:0]),
    .pll_locked(lo != rcwl_pkg::BLANK_WORD),
    .config_word_low(lo), .config_word_high(hi), .reset_status_reg(st), .system_pll_mode_reg(pll),
    .core_in_reset(cir));
  rcwl_byte_src flash (.clk(clk), .arst_n(arst_n), .req(f_rd.req), .image(image), .wait_cycles(wt),
    .fail(1'b0), .ack(f_ack), .err(), .data(f_data));
  rcwl_byte_src eeprom (.clk(clk), .arst_n(arst_n), .req(i_req), .image(image), .wait_cycles(wt),
    .fail(fail), .ack(i_ack), .err(i_err), .data(i_data));
  // boot engine answers with a crc fault, which must stay silent
  always @(posedge clk) begin
    if (start) begin
      seen_boot <= 1'b1;
      #1 done = 1'b1;
      crc = 1'b1;
      @(posedge clk);
      #1 done = 1'b0;
      crc = 1'b0;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic arm();
    en = 1'b1;
    repeat (3) @(posedge clk);
    #1 en = 1'b0;
  endtask : arm
  task automatic run(input logic [2:0] src, input logic [63:0] img, input logic fl,
      input logic [63:0] exp_w, input logic [3:0] exp_st);
    int n;
    strap = src;
    image = img;
    fail = fl;
    ext_hard = 1'b0;
    seen_boot = 1'b0;
    por_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 por_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 strap = ~src;
    if (arm_ovr) arm();
    arm_ovr = 1'b0;
    for (n = 0; n < 300 && hard_oe; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    #1 check(cir, 1'b1);
    check(seen_boot, 1'b0);
    check(i_rst, 1'b1);
    check(soft_oe, 1'b1);
    ext_hard = 1'b1;
    for (n = 0; n < 300 && cir; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    #1;
    check(i_rst, 1'b0);
    check(soft_oe, 1'b0);
    if (fl) check(st[0], 1'b1);
    else begin
      check(lo, exp_w[63:32]);
      check(hi, exp_w[31:0]);
      check(st[3:0], exp_st);
      check(pll[31:24], {exp_w[63:32] != rcwl_pkg::BLANK_WORD, exp_w[62:56]});
      check(cir, 1'b0);
    end
    $display("test done: source %h", src);
  endtask : run
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    run(3'h0, IMG_A, 1'b0, IMG_A, 4'h0);
    arm_ovr = 1'b1;
    run(3'h0, IMG_A, 1'b0, OVR, 4'h4);
    wt = 4'h2;
    run(3'h1, IMG_A, 1'b0, IMG_A, 4'h0);
    arm_ovr = 1'b1;
    run(3'h2, IMG_B, 1'b0, IMG_B, 4'h2);
    for (int k = 3; k < 8; k++) run(k[2:0], IMG_A, 1'b0, {rcwl_pkg::HC_LOW[k-3], rcwl_pkg::HC_HIGH[k-3]}, 4'h8);
    run(3'h2, IMG_B, 1'b1, IMG_B, 4'h0);
    run(3'h0, {2{rcwl_pkg::BLANK_WORD}}, 1'b0, {2{rcwl_pkg::BLANK_WORD}}, 4'h0);
    run(3'h0, IMG_BOOT, 1'b0, IMG_BOOT, 4'h0);
    check(seen_boot, 1'b1);
    stop_test();
  end
endmodule : rcwl_top_bench

// ===== test/rcwl_top_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module rcwl_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // reset lines
  input wire logic power_on_reset_line_n,
  input wire logic hard_reset_line_in,
  input wire logic hard_reset_line_oe,
  input wire logic hard_reset_line_out,
  input wire logic soft_reset_line_out,
  // loaders
  input rcwl_pkg::rcwl_rd_req_t flash_rd,
  input wire logic flash_ack,
  input wire logic i2c_rd_req,
  input wire logic i2c_err,
  input wire logic [6:0] i2c_call_addr,
  // boot and views
  input wire logic boot_seq_start,
  input wire logic boot_seq_crc_bad,
  input wire logic [31:0] config_word_high,
  input wire logic [31:0] reset_status_reg,
  input wire logic core_in_reset
);
  logic [2:0] acks_q;
  // count restarts with each request, so a stuck address shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) acks_q <= 3'h0;
    else if (!flash_rd.req) acks_q <= 3'h0;
    else if (flash_ack) acks_q <= acks_q + 3'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_flash_addr_step: assert property (flash_rd.req && flash_ack |-> flash_rd.addr == {18'h0, acks_q, 3'h0})
    else $error("flash address off step");
  a_por_restart: assert property ($fell(power_on_reset_line_n) |-> ##[1:6] (core_in_reset && hard_reset_line_oe))
    else $error("power-on did not restart");
  a_i2c_in_reset: assert property (i2c_rd_req |-> core_in_reset && hard_reset_line_oe && !flash_rd.req)
    else $error("i2c load outside reset");
  a_boot_after_hard: assert property (boot_seq_start |-> $past(hard_reset_line_in, 2) && !hard_reset_line_oe)
    else $error("boot before hard release");
  a_boot_by_field: assert property (boot_seq_start |-> config_word_high[31:30] != 2'h0)
    else $error("boot with field off");
  a_fail_flag_set: assert property (i2c_rd_req && i2c_err |-> ##[1:4] reset_status_reg[0])
    else $error("fail flag not set");
  a_crc_silent: assert property (boot_seq_crc_bad |=> $stable(reset_status_reg))
    else $error("crc fault changed status");
  a_lines_low_only: assert property (hard_reset_line_out == 1'b0 && soft_reset_line_out == 1'b0)
    else $error("reset line driven high");
  a_no_ovr_i2c: assert property (!(reset_status_reg[1] && reset_status_reg[2]))
    else $error("override on i2c path");
  a_call_addr_fixed: assert property (i2c_call_addr == 7'h50)
    else $error("calling address moved");
  c_flash_byte: cover property (flash_rd.req && flash_ack);
  c_i2c_fail: cover property (i2c_rd_req && i2c_err);
  c_boot_run: cover property (boot_seq_start);
endmodule : rcwl_top_sva

bind rcwl_top rcwl_top_sva u_sva (.clk, .arst_n, .power_on_reset_line_n, .hard_reset_line_in, .hard_reset_line_oe,
  .hard_reset_line_out, .soft_reset_line_out, .flash_rd, .flash_ack, .i2c_rd_req, .i2c_err, .i2c_call_addr,
  .boot_seq_start, .boot_seq_crc_bad, .config_word_high, .reset_status_reg, .core_in_reset);
